// ===== core/path_sel_pkg.sv
// Constants shared by the output path selector and its bench
package path_sel_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_WAVE = 8'h00;
  localparam logic [7:0] OFS_FREQ = 8'h04;
  localparam logic [7:0] OFS_PHASE = 8'h08;
  localparam logic [7:0] OFS_SYM = 8'h0c;
  localparam logic [7:0] OFS_OPTIONS = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Waveform codes
  localparam logic [2:0] W_SINE = 3'h0;
  localparam logic [2:0] W_SQUARE = 3'h1;
  localparam logic [2:0] W_TRIANGLE = 3'h2;
  localparam logic [2:0] W_PULSE = 3'h3;
  localparam logic [2:0] W_RAMP = 3'h4;
  localparam logic [2:0] W_STAIR = 3'h5;
  localparam logic [2:0] W_ARB = 3'h6;
  localparam logic [2:0] W_NOISE = 3'h7;
  // Three-way option settings
  localparam logic [1:0] SEL_AUTO = 2'h0;
  localparam logic [1:0] SEL_LOW = 2'h1;
  localparam logic [1:0] SEL_HIGH = 2'h2;
  localparam logic [1:0] FILT_AUTO = 2'h0;
  localparam logic [1:0] FILT_ON = 2'h1;
  localparam logic [1:0] FILT_OFF = 2'h2;
  localparam logic [1:0] REAR_AUTO = 2'h0;
  localparam logic [1:0] REAR_SWEEP = 2'h1;
  localparam logic [1:0] REAR_TRIG = 2'h2;
  // Options register field positions
  localparam int OPT_SQ_LSB = 0;
  localparam int OPT_FILT_LSB = 2;
  localparam int OPT_AUX_LSB = 4;
  localparam int OPT_REAR_LSB = 6;
  localparam int OPT_LIMIT_BIT = 8;
  // Mode register bit positions
  localparam int MODE_SWEEP_BIT = 0;
  localparam int MODE_FSK_BIT = 1;
  localparam int MODE_HOP_BIT = 2;
  localparam int MODE_TSYNC_BIT = 3;
  // Status register bit positions
  localparam int ST_ERR_BIT = 8;
  // Rear output roles and levels
  localparam logic [1:0] ROLE_SWEEP = 2'h0;
  localparam logic [1:0] ROLE_HOP = 2'h1;
  localparam logic [1:0] ROLE_TRIG = 2'h2;
  localparam logic [1:0] LVL_LOW = 2'h0;
  localparam logic [1:0] LVL_MARK = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  // Frequency thresholds in Hz
  localparam logic [31:0] CHANGEOVER_HZ = 32'h0000_7530;
  localparam logic [31:0] LIMIT_HZ = 32'h0001_86a0;
  // Reset values
  localparam logic [31:0] FREQ_RST = 32'h0000_2710;
  localparam logic [15:0] SYM_RST = 16'h8000;
endpackage

// ===== core/dds_output_path_selector.sv
// Output path selector: square, aux, filter and rear output routing
`timescale 1ns/1ns
`default_nettype none
module dds_output_path_selector
  import path_sel_pkg::*;
#(
  parameter int PHASE_W = 16
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] phase_acc,
  input wire logic comparator_in,
  input wire logic sweep_active,
  input wire logic sweep_marker,
  input wire logic hop_step,
  input wire logic trigger_gen,
  output logic main_square,
  output logic aux_square,
  output logic square_from_comparator,
  output logic aux_from_comparator,
  output logic elliptic_filter_en,
  output logic rc_filter_en,
  output logic [1:0] rear_trigger_sweep_output,
  output logic [1:0] rear_role
);

  // Widths the phase compare can serve
  if (PHASE_W < 4 || PHASE_W > 16) begin : g_bad_width
    $error("PHASE_W must lie between 4 and 16");
  end

  typedef struct packed {
    logic [2:0] wave;
    logic [31:0] freq;
    logic [PHASE_W-1:0] phase;
    logic [PHASE_W-1:0] sym;
    logic [1:0] square_generation_select;
    logic [1:0] filt_sel;
    logic [1:0] aux_sel;
    logic [1:0] rear_output_function_select;
    logic frequency_limit_enable;
    logic sweep_on;
    logic fsk_on;
    logic frequency_sequence_mode;
    logic trig_sync;
    logic held_hf;
    logic err;
    logic [2:0] cmp_pipe;
    logic cmp_lvl;
    logic acc_msb_d;
    logic trig_lat;
    logic main_sq;
    logic aux_sq;
    logic sq_hf;
    logic aux_hf;
    logic filt_on;
    logic rc_on;
    logic [1:0] rear_lvl;
    logic [1:0] role;
    logic ack;
    logic slverr;
    logic [31:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // Triangle, ramp, staircase, arbitrary degrade at high frequency
  function automatic logic is_slow(input logic [2:0] w);
    return (w == W_TRIANGLE) || (w == W_RAMP) || (w == W_STAIR) || (w == W_ARB);
  endfunction

  function automatic logic is_ramp_like(input logic [2:0] w);
    return (w == W_RAMP) || (w == W_STAIR) || (w == W_ARB);
  endfunction

  function automatic logic is_square(input logic [2:0] w);
    return (w == W_SQUARE) || (w == W_PULSE);
  endfunction

  logic [PHASE_W-1:0] acc_top;
  logic [PHASE_W-1:0] aux_pos;
  logic wr_now;
  logic rd_setup;
  logic above_co;
  logic auto_hf;
  logic frozen;
  logic zero_cross;

  assign acc_top = phase_acc[31 -: PHASE_W];
  assign aux_pos = acc_top - st_ff.phase;
  assign wr_now = psel && penable && pwrite && st_ff.ack;
  assign rd_setup = psel && penable && !st_ff.ack;
  assign above_co = st_ff.freq > CHANGEOVER_HZ;
  assign frozen = st_ff.sweep_on || st_ff.fsk_on;
  assign auto_hf = frozen ? st_ff.held_hf : above_co;
  assign zero_cross = st_ff.acc_msb_d && !phase_acc[31];

  // Next-state logic; every selection recomputed each cycle
  always_comb begin
    nxt_st = st_ff;
    // Bus answer one cycle into the access phase
    nxt_st.ack = rd_setup;
    nxt_st.slverr = 1'b0;
    if (rd_setup) begin
      unique case (paddr)
        OFS_WAVE: nxt_st.rdata = {29'h0, st_ff.wave};
        OFS_FREQ: nxt_st.rdata = st_ff.freq;
        OFS_PHASE: nxt_st.rdata = 32'(st_ff.phase);
        OFS_SYM: nxt_st.rdata = 32'(st_ff.sym);
        OFS_OPTIONS: nxt_st.rdata = {23'h0, st_ff.frequency_limit_enable, st_ff.rear_output_function_select,
          st_ff.aux_sel, st_ff.filt_sel, st_ff.square_generation_select};
        OFS_MODE: nxt_st.rdata = {28'h0, st_ff.trig_sync, st_ff.frequency_sequence_mode,
          st_ff.fsk_on, st_ff.sweep_on};
        OFS_STATUS: nxt_st.rdata = {23'h0, st_ff.err, 2'h0, st_ff.role, st_ff.rc_on,
          st_ff.filt_on, st_ff.aux_hf, st_ff.sq_hf};
        default: begin
          nxt_st.rdata = 32'h0;
          nxt_st.slverr = 1'b1;
        end
      endcase
    end
    // Writes take effect at the edge that sees pready high
    if (wr_now) begin
      unique case (paddr)
        OFS_WAVE: begin
          if (st_ff.frequency_limit_enable && is_slow(pwdata[2:0]) && st_ff.freq > LIMIT_HZ) begin
            nxt_st.err = 1'b1;
          end else begin
            nxt_st.wave = pwdata[2:0];
          end
        end
        OFS_FREQ: begin
          if (st_ff.frequency_limit_enable && is_slow(st_ff.wave) && pwdata > LIMIT_HZ) begin
            nxt_st.err = 1'b1;
          end else begin
            nxt_st.freq = pwdata;
          end
        end
        OFS_PHASE: nxt_st.phase = pwdata[PHASE_W-1:0];
        OFS_SYM: nxt_st.sym = pwdata[PHASE_W-1:0];
        OFS_OPTIONS: begin
          nxt_st.square_generation_select = pwdata[OPT_SQ_LSB +: 2];
          nxt_st.filt_sel = pwdata[OPT_FILT_LSB +: 2];
          nxt_st.aux_sel = pwdata[OPT_AUX_LSB +: 2];
          nxt_st.rear_output_function_select = pwdata[OPT_REAR_LSB +: 2];
          nxt_st.frequency_limit_enable = pwdata[OPT_LIMIT_BIT];
        end
        OFS_MODE: begin
          nxt_st.sweep_on = pwdata[MODE_SWEEP_BIT];
          nxt_st.fsk_on = pwdata[MODE_FSK_BIT];
          nxt_st.frequency_sequence_mode = pwdata[MODE_HOP_BIT];
          nxt_st.trig_sync = pwdata[MODE_TSYNC_BIT];
        end
        OFS_STATUS: begin
          // A rejection in this same cycle is impossible, so clear is safe
          if (pwdata[ST_ERR_BIT]) begin
            nxt_st.err = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Auto decision tracked outside sweep/FSK, frozen inside
    if (!frozen) begin
      nxt_st.held_hf = above_co;
    end
    // Three-stage comparator synchroniser; level moves once stages 2 and 3 agree
    nxt_st.cmp_pipe = {st_ff.cmp_pipe[1:0], comparator_in};
    if (st_ff.cmp_pipe[1] == st_ff.cmp_pipe[2]) begin
      nxt_st.cmp_lvl = st_ff.cmp_pipe[2];
    end
    // Square generation mode
    unique case (st_ff.square_generation_select)
      SEL_LOW: nxt_st.sq_hf = 1'b0;
      SEL_HIGH: nxt_st.sq_hf = 1'b1;
      default: nxt_st.sq_hf = auto_hf;
    endcase
    // Aux generation mode
    unique case (st_ff.aux_sel)
      SEL_LOW: nxt_st.aux_hf = 1'b0;
      SEL_HIGH: nxt_st.aux_hf = 1'b1;
      default: nxt_st.aux_hf = !is_ramp_like(st_ff.wave) && (st_ff.wave != W_NOISE) && above_co;
    endcase
    // Digital squares: high from zero phase for the symmetry fraction
    nxt_st.main_sq = st_ff.sq_hf ? st_ff.cmp_lvl : (acc_top < st_ff.sym);
    nxt_st.aux_sq = st_ff.aux_hf ? st_ff.cmp_lvl : (aux_pos < st_ff.sym);
    // Filter routing
    if (st_ff.wave == W_NOISE) begin
      nxt_st.filt_on = 1'b0;
      nxt_st.rc_on = 1'b1;
    end else begin
      nxt_st.rc_on = 1'b0;
      unique case (st_ff.filt_sel)
        FILT_ON: nxt_st.filt_on = 1'b1;
        FILT_OFF: nxt_st.filt_on = 1'b0;
        default: nxt_st.filt_on = (st_ff.wave == W_SINE) || (st_ff.wave == W_TRIANGLE) ||
          (is_square(st_ff.wave) && st_ff.sq_hf);
      endcase
    end
    // Trigger retimed to main zero phase only in the synchronised modes
    nxt_st.acc_msb_d = phase_acc[31];
    if (!st_ff.trig_sync) begin
      nxt_st.trig_lat = trigger_gen;
    end else if (zero_cross) begin
      nxt_st.trig_lat = trigger_gen;
    end
    // Rear output role
    unique case (st_ff.rear_output_function_select)
      REAR_SWEEP: nxt_st.role = st_ff.frequency_sequence_mode ? ROLE_HOP : ROLE_SWEEP;
      REAR_TRIG: nxt_st.role = ROLE_TRIG;
      default: nxt_st.role = st_ff.sweep_on ? ROLE_SWEEP :
        (st_ff.frequency_sequence_mode ? ROLE_HOP : ROLE_TRIG);
    endcase
    // Rear output level for the current role
    unique case (st_ff.role)
      ROLE_SWEEP: nxt_st.rear_lvl = !sweep_active ? LVL_HIGH : (sweep_marker ? LVL_MARK : LVL_LOW);
      ROLE_HOP: nxt_st.rear_lvl = hop_step ? LVL_HIGH : LVL_LOW;
      default: nxt_st.rear_lvl = st_ff.trig_lat ? LVL_HIGH : LVL_LOW;
    endcase
  end

  // Single state register, synchronous reset
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_ff <= '{wave: W_SINE, freq: FREQ_RST, phase: '0, sym: SYM_RST[15 -: PHASE_W],
        square_generation_select: SEL_AUTO, filt_sel: FILT_AUTO, aux_sel: SEL_AUTO,
        rear_output_function_select: REAR_AUTO, rear_lvl: LVL_HIGH, role: ROLE_TRIG,
        rdata: 32'h0, cmp_pipe: 3'h0, default: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.rdata;
  assign pready = st_ff.ack;
  assign pslverr = st_ff.slverr;
  assign main_square = st_ff.main_sq;
  assign aux_square = st_ff.aux_sq;
  assign square_from_comparator = st_ff.sq_hf;
  assign aux_from_comparator = st_ff.aux_hf;
  assign elliptic_filter_en = st_ff.filt_on;
  assign rc_filter_en = st_ff.rc_on;
  assign rear_trigger_sweep_output = st_ff.rear_lvl;
  assign rear_role = st_ff.role;

  // Checks on the selection behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_freq_write_high;
    wr_now && paddr == OFS_FREQ && pwdata > LIMIT_HZ;
  endsequence

  sequence s_limit_slow;
    st_ff.frequency_limit_enable && is_slow(st_ff.wave);
  endsequence

  a_freq_reject_err: assert property (s_limit_slow ##0 s_freq_write_high |=>
    st_ff.err && st_ff.freq == $past(st_ff.freq))
    else $error("slow-wave frequency above limit was accepted");

  a_wave_reject_err: assert property (wr_now && paddr == OFS_WAVE && st_ff.frequency_limit_enable &&
    is_slow(pwdata[2:0]) && st_ff.freq > LIMIT_HZ |=> st_ff.err && $stable(st_ff.wave))
    else $error("slow waveform selected above limit");

  a_nolimit_accept: assert property (!st_ff.frequency_limit_enable ##0 s_freq_write_high |=>
    st_ff.freq == $past(pwdata))
    else $error("frequency refused with limit off");

  a_noise_filter: assert property (st_ff.wave == W_NOISE |=> !elliptic_filter_en && rc_filter_en)
    else $error("noise not routed through RC filter");

  a_filter_forced: assert property (st_ff.wave != W_NOISE && st_ff.filt_sel == FILT_OFF |=>
    !elliptic_filter_en)
    else $error("forced-off filter switched in");

  a_sq_auto_co: assert property (st_ff.square_generation_select == SEL_AUTO && !frozen && above_co
    |=> square_from_comparator)
    else $error("auto square mode stayed low above changeover");

  a_sweep_hold_mode: assert property (frozen && $past(frozen) && st_ff.square_generation_select == SEL_AUTO
    |=> square_from_comparator == $past(square_from_comparator))
    else $error("square mode changed during sweep");

  a_aux_ramp_digital: assert property (st_ff.aux_sel == SEL_AUTO && is_ramp_like(st_ff.wave)
    |=> !aux_from_comparator)
    else $error("ramp-like aux left digital mode");

  a_aux_forced_high: assert property (st_ff.aux_sel == SEL_HIGH |=> aux_from_comparator)
    else $error("forced-high aux not from comparator");

  a_rear_trig_role: assert property (st_ff.rear_output_function_select == REAR_TRIG |=>
    rear_role == ROLE_TRIG)
    else $error("forced trigger role not taken");

  a_sweep_low_level: assert property (st_ff.role == ROLE_SWEEP && sweep_active && !sweep_marker |=>
    rear_trigger_sweep_output == LVL_LOW)
    else $error("rear output not low during sweep");

  a_aux_zero_phase: assert property (!st_ff.aux_hf && !st_ff.sq_hf && st_ff.phase == '0 |=>
    aux_square == main_square)
    else $error("aux edge not aligned at zero phase");

  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle wide");

endmodule // dds_output_path_selector
`default_nettype wire

// ===== sim/analog_chain_model.sv
// Far-side model: phase accumulator, sine comparator, sweep, hop and trigger sources
`timescale 1ns/1ns
`default_nettype none
module analog_chain_model #(
  parameter logic [31:0] STEP = 32'h0400_0000
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic sweep_on,
  input wire logic hop_on,
  output logic [31:0] phase_acc,
  output logic comparator_in,
  output logic sweep_active,
  output logic sweep_marker,
  output logic hop_step,
  output logic trigger_gen
);
  logic [7:0] cnt_ff;
  // Positive half of the sine turn drives the comparator high
  assign comparator_in = ~phase_acc[31];
  // Period of 64 cycles keeps phase lags countable in whole cycles
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      phase_acc <= 32'h0;
      cnt_ff <= 8'h0;
      sweep_active <= 1'b0;
      sweep_marker <= 1'b0;
      hop_step <= 1'b0;
      trigger_gen <= 1'b0;
    end else begin
      phase_acc <= phase_acc + STEP;
      cnt_ff <= cnt_ff + 8'h1;
      sweep_active <= sweep_on && (cnt_ff < 8'd160);
      sweep_marker <= sweep_on && (cnt_ff >= 8'd80) && (cnt_ff < 8'd84);
      hop_step <= hop_on && cnt_ff[4];
      trigger_gen <= cnt_ff[3]; // Free-running, locked to the main phase; high at every phase wrap
    end
  end
endmodule // analog_chain_model
`default_nettype wire

// ===== sim/test_dds_output_path_selector.sv
// Self-checking bench for the output path selector
`timescale 1ns/1ns
`default_nettype none
module test_dds_output_path_selector;
  import path_sel_pkg::*;
  logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, phase_acc, rv;
  logic pready, pslverr, comparator_in, sweep_active, sweep_marker, hop_step, trigger_gen;
  logic main_square, aux_square, square_from_comparator, aux_from_comparator, elliptic_filter_en, rc_filter_en;
  logic sweep_on = 1'b0, hop_on = 1'b0;
  logic [1:0] rear_trigger_sweep_output, rear_role;
  logic [2:0] in_d, in_dd;
  int num_errors = 0, n_checks = 0, cyc = 0;

  always #25 core_clk = ~core_clk;

  dds_output_path_selector DUT (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_acc(phase_acc), .comparator_in(comparator_in), .sweep_active(sweep_active),
    .sweep_marker(sweep_marker), .hop_step(hop_step), .trigger_gen(trigger_gen), .main_square(main_square),
    .aux_square(aux_square), .square_from_comparator(square_from_comparator),
    .aux_from_comparator(aux_from_comparator), .elliptic_filter_en(elliptic_filter_en),
    .rc_filter_en(rc_filter_en), .rear_trigger_sweep_output(rear_trigger_sweep_output), .rear_role(rear_role));

  analog_chain_model far_side (.core_clk(core_clk), .nrst(nrst), .sweep_on(sweep_on), .hop_on(hop_on),
    .phase_acc(phase_acc), .comparator_in(comparator_in), .sweep_active(sweep_active),
    .sweep_marker(sweep_marker), .hop_step(hop_step), .trigger_gen(trigger_gen));

  // Input history, so level checks skip cycles right after a change
  always @(posedge core_clk) begin
    in_d <= {sweep_active, sweep_marker, trigger_gen};
    in_dd <= in_d;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask

  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee,
                     output logic [31:0] r);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // No local count; pready or the bench cycle limit ends this wait
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    chkb("pslverr", ee, pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, rv);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0, rv);
    chk(nm, e, rv);
  endtask

  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask

  task automatic cfg(input logic [2:0] w, input logic [31:0] f, input logic [31:0] o);
    wr(OFS_OPTIONS, o);
    wr(OFS_WAVE, 32'(w));
    wr(OFS_FREQ, f);
    settle();
  endtask

  // Reset values, read-only status and unmapped offsets
  task automatic t_regs();
    rd_chk("wave", OFS_WAVE, 32'h0);
    rd_chk("freq", OFS_FREQ, FREQ_RST);
    rd_chk("phase", OFS_PHASE, 32'h0);
    rd_chk("sym", OFS_SYM, 32'(SYM_RST));
    rd_chk("opts", OFS_OPTIONS, 32'h0);
    rd_chk("mode", OFS_MODE, 32'h0);
    wr(OFS_STATUS, 32'h3f);
    rd_chk("status", OFS_STATUS, 32'h24);
    apb(1'b0, 8'h1c, 32'h0, 1'b1, rv);
    chk("unmapped rd", 32'h0, rv);
    apb(1'b1, 8'h20, 32'h1, 1'b1, rv);
  endtask

  // Square mode changeover and forced modes
  task automatic t_square();
    cfg(W_SQUARE, 32'd30000, 32'h0);
    chkb("sq hf 30000", 1'b0, square_from_comparator);
    chkb("filt lf sq", 1'b0, elliptic_filter_en);
    cfg(W_SQUARE, 32'd30001, 32'h0);
    chkb("sq hf 30001", 1'b1, square_from_comparator);
    chkb("filt hf sq", 1'b1, elliptic_filter_en);
    cfg(W_PULSE, 32'd50000, 32'h1);
    chkb("sq forced low", 1'b0, square_from_comparator);
    cfg(W_PULSE, 32'd10000, 32'h2);
    chkb("sq forced high", 1'b1, square_from_comparator);
  endtask

  // Filter choice for every waveform, then forced settings
  task automatic t_filter();
    logic [7:0] fe;
    fe = 8'h05;
    for (int w = 0; w < 8; w++) begin
      cfg(3'(w), 32'd10000, 32'h0);
      chkb("ellip auto", fe[w], elliptic_filter_en);
      chkb("rc auto", w == 7, rc_filter_en);
    end
    cfg(W_RAMP, 32'd10000, 32'h4);
    chkb("ellip on", 1'b1, elliptic_filter_en);
    cfg(W_NOISE, 32'd10000, 32'h4);
    chkb("ellip noise", 1'b0, elliptic_filter_en);
    cfg(W_SINE, 32'd10000, 32'h8);
    chkb("ellip off", 1'b0, elliptic_filter_en);
  endtask

  // Auxiliary source selection
  task automatic t_aux();
    cfg(W_SINE, 32'd50000, 32'h0);
    chkb("aux auto sine", 1'b1, aux_from_comparator);
    cfg(W_RAMP, 32'd50000, 32'h0);
    chkb("aux auto ramp", 1'b0, aux_from_comparator);
    cfg(W_SINE, 32'd50000, 32'h10);
    chkb("aux low", 1'b0, aux_from_comparator);
    cfg(W_ARB, 32'd10000, 32'h20);
    chkb("aux high", 1'b1, aux_from_comparator);
  endtask

  // Comparator-fed main and aux squares follow the synchronised pin
  task automatic t_cmp();
    logic pm;
    int n;
    cfg(W_SQUARE, 32'd50000, 32'h22);
    n = 0;
    do begin
      pm = main_square;
      @(posedge core_clk);
      #1;
      n++;
    end while (!(main_square === 1'b1 && pm === 1'b0) && n < 200);
    chkb("cmp main edge", 1'b1, phase_acc >= 32'h1000_0000 && phase_acc <= 32'h1800_0000);
    chkb("cmp aux", 1'b1, aux_square === main_square);
  endtask

  // Aux lag against main in cycles of a 64-cycle period
  task automatic t_phase();
    logic [15:0] ph[3];
    int ex[3];
    int n, d, e;
    logic pm, pa;
    ph = '{16'h0000, 16'h4000, 16'hc000};
    ex = '{0, 16, 48};
    cfg(W_SQUARE, 32'd10000, 32'h11);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_PHASE, 32'(ph[i]));
      settle();
      n = 0;
      do begin
        pm = main_square;
        @(posedge core_clk);
        #1;
        n++;
      end while (!(main_square === 1'b1 && pm === 1'b0) && n < 200);
      chkb("zero phase", 1'b1, phase_acc < 32'h1000_0000);
      d = 0;
      do begin
        pa = aux_square;
        @(posedge core_clk);
        #1;
        d++;
      end while (!(aux_square === 1'b1 && pa === 1'b0) && d < 200);
      e = (d - ex[i] + 96) % 64 - 32;
      chkb("aux lag", 1'b1, e >= -1 && e <= 1);
    end
  endtask

  // Frequency limit: both refusal paths, sticky error, limit off
  task automatic t_limit();
    cfg(W_SINE, 32'd10000, 32'h100);
    wr(OFS_WAVE, 32'(W_TRIANGLE));
    wr(OFS_FREQ, 32'd100000);
    rd_chk("freq at limit", OFS_FREQ, 32'd100000);
    wr(OFS_FREQ, 32'd100001);
    rd_chk("freq refused", OFS_FREQ, 32'd100000);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0, rv);
    chkb("err set", 1'b1, rv[ST_ERR_BIT]);
    wr(OFS_STATUS, 32'h100);
    wr(OFS_WAVE, 32'(W_SINE));
    wr(OFS_FREQ, 32'd200000);
    wr(OFS_WAVE, 32'(W_STAIR));
    rd_chk("wave refused", OFS_WAVE, 32'(W_SINE));
    wr(OFS_OPTIONS, 32'h0);
    wr(OFS_STATUS, 32'h100);
    wr(OFS_WAVE, 32'(W_ARB));
    rd_chk("wave free", OFS_WAVE, 32'(W_ARB));
    wr(OFS_FREQ, 32'd300000);
    rd_chk("freq free", OFS_FREQ, 32'd300000);
    apb(1'b0, OFS_STATUS, 32'h0, 1'b0, rv);
    chkb("err clear", 1'b0, rv[ST_ERR_BIT]);
  endtask

  // Square mode frozen while sweeping
  task automatic t_hold();
    cfg(W_SQUARE, 32'd10000, 32'h0);
    wr(OFS_MODE, 32'h1);
    wr(OFS_FREQ, 32'd50000);
    settle();
    chkb("sq held", 1'b0, square_from_comparator);
    wr(OFS_MODE, 32'h0);
    settle();
    chkb("sq after sweep", 1'b1, square_from_comparator);
  endtask

  task automatic watch(input logic trig);
    logic [1:0] x;
    for (int i = 0; i < 200; i++) begin
      @(posedge core_clk);
      #1;
      x = trig ? (in_d[0] ? LVL_HIGH : LVL_LOW) : (!in_d[2] ? LVL_HIGH : in_d[1] ? LVL_MARK : LVL_LOW);
      if (in_d === in_dd) begin
        chk("rear out", 32'(x), 32'(rear_trigger_sweep_output));
      end
    end
  endtask

  // Rear output roles and levels
  task automatic t_rear();
    cfg(W_SINE, 32'd10000, 32'h0);
    sweep_on <= 1'b1;
    wr(OFS_MODE, 32'h1);
    settle();
    chk("role auto sweep", 32'(ROLE_SWEEP), 32'(rear_role));
    watch(1'b0);
    sweep_on <= 1'b0;
    hop_on <= 1'b1;
    wr(OFS_MODE, 32'h4);
    settle();
    chk("role auto hop", 32'(ROLE_HOP), 32'(rear_role));
    wr(OFS_OPTIONS, 32'h40);
    settle();
    chk("role forced hop", 32'(ROLE_HOP), 32'(rear_role));
    hop_on <= 1'b0;
    wr(OFS_MODE, 32'h0);
    settle();
    chk("role forced sweep", 32'(ROLE_SWEEP), 32'(rear_role));
    wr(OFS_OPTIONS, 32'h80);
    wr(OFS_MODE, 32'h1);
    settle();
    chk("role trig", 32'(ROLE_TRIG), 32'(rear_role));
    watch(1'b1);
  endtask

  // Retimed trigger: the model's trigger is high at every phase wrap
  task automatic t_tsync();
    wr(OFS_MODE, 32'h8);
    repeat (70) @(posedge core_clk);
    #1;
    for (int i = 0; i < 128; i++) begin
      chk("rear sync", 32'(LVL_HIGH), 32'(rear_trigger_sweep_output));
      @(posedge core_clk);
      #1;
    end
  endtask

  initial begin
    repeat (7) @(posedge core_clk);
    #1;
    chkb("rst sq", 1'b0, square_from_comparator);
    chk("rst rear", 32'(LVL_HIGH), 32'(rear_trigger_sweep_output));
    @(posedge core_clk);
    nrst <= 1'b1;
    settle();
    t_regs();
    t_square();
    t_filter();
    t_aux();
    t_cmp();
    t_phase();
    t_limit();
    t_hold();
    t_rear();
    t_tsync();
    stop_test();
  end
endmodule // test_dds_output_path_selector
`default_nettype wire
